// file: rtl/tw_eeprom_dev.sv
/*
  memory end of the two-wire link: start/stop detection, address match,
  acknowledge, 16-byte page capture and the self-timed write cycle.
  assumes the link clock stands still between frames; bits are taken on the
  link clock, the write cycle and memory write port run on clk_sys.
*/
`timescale 1ns/1ps

module tw_eeprom_dev #(
  parameter int unsigned WR_CYCLES = tw_pkg::WR_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  tw_if.device link,
  input wire logic chip_select_strap_2,
  input wire logic chip_select_strap_1,
  input wire logic chip_select_strap_0,
  input wire logic write_protect,
  input wire logic reversible_half_lock_flag,
  output logic mem_we,
  output tw_pkg::tw_byte_t mem_addr,
  output tw_pkg::tw_byte_t mem_wdata,
  output logic write_busy,
  output logic permanent_half_lock_flag
);
  import tw_pkg::*;

  logic start_tog_reg;
  logic stop_tog_reg;
  logic start_seen_reg;
  logic stop_seen_reg;
  tw_dev_state_t state_reg;
  logic [3:0] bitcnt_reg;
  logic [7:0] shift_reg;
  logic ack_reg;
  logic prot_reg;
  logic armed_reg;
  logic sda_oe_reg;
  logic [7:0] addr_reg;
  logic [7:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_reg;
  logic [4:0] lsync_m_reg;
  logic [4:0] lsync_s_reg;
  logic [4:0] ssync_m_reg;
  logic [4:0] ssync_s_reg;
  logic stop_d_reg;
  logic [31:0] timer_reg;
  logic [4:0] idx_reg;
  logic prot_c_reg;
  logic start_pend;
  logic stop_pend;
  logic [7:0] rx_byte;
  logic byte_end;
  logic dev_hit;
  logic code_lock;
  logic stop_evt;
  logic wr_allowed;

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = sda_oe_reg;

  // start and stop seen as data edges while the clock is high
  always_ff @(negedge link.sda or negedge reset_n) begin
    if (!reset_n) begin
      start_tog_reg <= 1'b0;
    end else if (link.scl) begin
      start_tog_reg <= ~start_tog_reg;
    end
  end

  always_ff @(posedge link.sda or negedge reset_n) begin
    if (!reset_n) begin
      stop_tog_reg <= 1'b0;
    end else if (link.scl) begin
      stop_tog_reg <= ~stop_tog_reg;
    end
  end

  // link-side view of straps, busy and lock
  always_ff @(posedge link.scl or negedge reset_n) begin
    if (!reset_n) begin
      lsync_m_reg <= 5'h00;
      lsync_s_reg <= 5'h00;
    end else begin
      lsync_m_reg <= {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0,
                      write_busy, permanent_half_lock_flag};
      lsync_s_reg <= lsync_m_reg;
    end
  end

  // toggles settle a full clock phase before the next rising edge
  assign start_pend = start_tog_reg != start_seen_reg;
  assign stop_pend = stop_tog_reg != stop_seen_reg;
  assign rx_byte = {shift_reg[6:0], link.sda};
  assign byte_end = !start_pend && !stop_pend && (bitcnt_reg == BIT_LAST) && (state_reg != DS_IDLE);
  assign code_lock = rx_byte[7:4] == CODE_LOCK;

  // address word decode
  always_comb begin
    dev_hit = (rx_byte[3:1] == lsync_s_reg[4:2])
              && !lsync_s_reg[1]
              && ((rx_byte[7:4] == CODE_MEM) || (code_lock && !lsync_s_reg[0]));
  end

  // frame sequencer on the link clock
  always_ff @(posedge link.scl or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= DS_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ack_reg <= 1'b0;
      prot_reg <= 1'b0;
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end else if (start_pend) begin
      start_seen_reg <= start_tog_reg;
      stop_seen_reg <= stop_tog_reg;
      state_reg <= DS_DEV;
      bitcnt_reg <= 4'h1;
      shift_reg <= {7'h00, link.sda};
      ack_reg <= 1'b0;
    end else if (stop_pend) begin
      stop_seen_reg <= stop_tog_reg;
      state_reg <= DS_IDLE;
      bitcnt_reg <= 4'h0;
      ack_reg <= 1'b0;
    end else if (state_reg == DS_IDLE) begin
      bitcnt_reg <= 4'h0;
      ack_reg <= 1'b0;
    end else if (bitcnt_reg == BIT_ACK) begin
      bitcnt_reg <= 4'h0;
      ack_reg <= 1'b0;
    end else begin
      shift_reg <= rx_byte;
      bitcnt_reg <= bitcnt_reg + 4'h1;
      if (bitcnt_reg == BIT_LAST) begin
        case (state_reg)
          DS_DEV: begin
            if (dev_hit) begin
              ack_reg <= 1'b1;
              prot_reg <= code_lock;
              state_reg <= rx_byte[0] ? DS_SKIP : DS_WADDR;
            end else begin
              state_reg <= DS_IDLE;
            end
          end
          DS_WADDR: begin
            ack_reg <= 1'b1;
            state_reg <= DS_DATA;
          end
          DS_DATA: begin
            ack_reg <= 1'b1;
          end
          DS_SKIP: begin
            ack_reg <= 1'b0;
          end
          default: begin
            state_reg <= DS_IDLE;
          end
        endcase
      end
    end
  end

  // acknowledge driven low over the whole ninth clock
  always_ff @(negedge link.scl or negedge reset_n) begin
    if (!reset_n) begin
      sda_oe_reg <= 1'b0;
    end else begin
      sda_oe_reg <= ack_reg && (bitcnt_reg == BIT_ACK);
    end
  end

  // word address: load, then step the byte nibble only
  always_ff @(posedge link.scl or negedge reset_n) begin
    if (!reset_n) begin
      addr_reg <= ADDR_RST;
    end else if (byte_end && state_reg == DS_WADDR) begin
      addr_reg <= rx_byte;
    end else if (byte_end && state_reg == DS_DATA) begin
      addr_reg[3:0] <= addr_reg[3:0] + 4'h1;
    end
  end

  // page capture buffer; a wrapped byte overwrites its slot
  always_ff @(posedge link.scl) begin
    if (byte_end && state_reg == DS_DATA) begin
      page_buf[addr_reg[3:0]] <= rx_byte;
    end
  end

  // slots filled this frame, and whether a stop should commit
  always_ff @(posedge link.scl or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg <= '0;
      armed_reg <= 1'b0;
    end else if (start_pend) begin
      armed_reg <= 1'b0;
    end else if (byte_end && state_reg == DS_WADDR) begin
      mask_reg <= '0;
      armed_reg <= prot_reg;
    end else if (byte_end && state_reg == DS_DATA) begin
      mask_reg[addr_reg[3:0]] <= 1'b1;
      armed_reg <= 1'b1;
    end
  end

  // system-side view of stop, arm, lock command and pins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ssync_m_reg <= 5'h00;
      ssync_s_reg <= 5'h00;
      stop_d_reg <= 1'b0;
    end else begin
      ssync_m_reg <= {stop_tog_reg, armed_reg, prot_reg, write_protect, reversible_half_lock_flag};
      ssync_s_reg <= ssync_m_reg;
      stop_d_reg <= ssync_s_reg[4];
    end
  end

  assign stop_evt = ssync_s_reg[4] ^ stop_d_reg;
  assign wr_allowed = !ssync_s_reg[1]
                      && !(!addr_reg[7] && (permanent_half_lock_flag || ssync_s_reg[0]));

  // self-timed write cycle; the full time runs even when writes are blocked
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      write_busy <= 1'b0;
      timer_reg <= 32'h0000_0000;
      idx_reg <= 5'h00;
      prot_c_reg <= 1'b0;
    end else if (!write_busy && stop_evt && ssync_s_reg[3]) begin
      write_busy <= 1'b1;
      timer_reg <= 32'h0000_0000;
      idx_reg <= 5'h00;
      prot_c_reg <= ssync_s_reg[2];
    end else if (write_busy) begin
      timer_reg <= timer_reg + 32'h0000_0001;
      if (!idx_reg[4]) begin
        idx_reg <= idx_reg + 5'h01;
      end
      if (timer_reg == WR_CYCLES - 32'h0000_0001) begin
        write_busy <= 1'b0;
      end
    end
  end

  // memory write port walks the page once per cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mem_we <= 1'b0;
      mem_addr <= ADDR_RST;
      mem_wdata <= 8'h00;
    end else begin
      mem_we <= write_busy && !idx_reg[4] && !prot_c_reg && mask_reg[idx_reg[3:0]] && wr_allowed;
      mem_addr <= {addr_reg[7:4], idx_reg[3:0]};
      mem_wdata <= page_buf[idx_reg[3:0]];
    end
  end

  // permanent lock, set by a locking write with the pin low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      permanent_half_lock_flag <= 1'b0;
    end else if (write_busy && idx_reg == 5'h00 && prot_c_reg && !ssync_s_reg[1]) begin
      permanent_half_lock_flag <= 1'b1;
    end
  end

endmodule

// file: rtl/tw_pkg.sv
/*
  shared constants and types for the two-wire memory write port: control codes,
  page layout, bit counts, timing counts and the state encodings of both ends.
  assumes a 50 MHz system clock on both ends.
*/
package tw_pkg;

  typedef logic [7:0] tw_byte_t;

  // control codes in the upper nibble of the address word
  localparam logic [3:0] CODE_MEM = 4'hA;
  localparam logic [3:0] CODE_LOCK = 4'h6;

  // word address layout: upper nibble page, lower nibble byte
  localparam int PAGE_BYTES = 16;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // internal programming time
  localparam int CLK_SYS_KHZ = 50000;
  localparam int INTERNAL_PROGRAM_TIME_MS = 5;
  localparam int WR_CYCLES_DEF = INTERNAL_PROGRAM_TIME_MS * CLK_SYS_KHZ;

  // master side link timing and recovery
  localparam logic [7:0] QTR_CYCLES = 8'h04;
  localparam logic [3:0] RECOVER_PULSES = 4'h9;

  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_DEV = 3'b001,
    DS_WADDR = 3'b010,
    DS_DATA = 3'b011,
    DS_SKIP = 3'b100
  } tw_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_RECOV = 3'b001,
    HS_START = 3'b010,
    HS_BIT = 3'b011,
    HS_ACK = 3'b100,
    HS_STOP = 3'b101
  } tw_host_state_t;

endpackage

// file: rtl/tw_if.sv
/*
  the two-wire link between the bus master and the memory port.
  the data wire is open drain with a pull-up; its level is worked out here
  from both drivers' enables. the master drives the clock wire alone.
*/
`timescale 1ns/1ps
interface tw_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // wired-and with pull-up
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe,
    input sda
  );

  modport device (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe
  );
endinterface

// file: rtl/tw_master.sv
/*
  bus master end of the two-wire link: makes the link clock by dividing
  clk_sys, sends write or poll frames and runs the nine-pulse recovery.
  assumes the user holds command fields stable while cmd_ready is low and
  presents the next data byte before each wr_data_taken pulse is due.
*/
`timescale 1ns/1ps
module tw_master (
  input wire logic clk_sys,
  input wire logic reset_n,
  tw_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_recover,
  input wire tw_pkg::tw_byte_t cmd_ctrl,
  input wire tw_pkg::tw_byte_t cmd_word_addr,
  input wire logic [4:0] cmd_len,
  input wire tw_pkg::tw_byte_t wr_data,
  output logic wr_data_taken,
  output logic done,
  output logic nack
);
  import tw_pkg::*;

  tw_host_state_t state_reg;
  logic [7:0] qcnt_reg;
  logic [1:0] q_reg;
  logic scl_reg;
  logic sda_oe_reg;
  logic sda_m_reg;
  logic sda_s_reg;
  logic [7:0] tx_reg;
  logic [2:0] bitn_reg;
  logic [5:0] nbyte_reg;
  logic [3:0] pulses_reg;
  logic sampled_reg;
  logic recov_reg;
  logic tick;
  logic last_byte;

  assign link.scl = scl_reg;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = sda_oe_reg;

  // data wire back in through two flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else begin
      sda_m_reg <= link.sda;
      sda_s_reg <= sda_m_reg;
    end
  end

  // quarter-period divider for the link clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      qcnt_reg <= 8'h00;
    end else if (tick) begin
      qcnt_reg <= 8'h00;
    end else begin
      qcnt_reg <= qcnt_reg + 8'h01;
    end
  end

  assign tick = qcnt_reg == QTR_CYCLES - 8'h01;
  assign last_byte = cmd_ctrl[0] ? (nbyte_reg == 6'h00) : (nbyte_reg == {1'b0, cmd_len} + 6'h01);

  // frame sequencer, one link bit per four quarters
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= HS_IDLE;
      q_reg <= 2'h0;
      scl_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
      tx_reg <= 8'h00;
      bitn_reg <= 3'h0;
      nbyte_reg <= 6'h00;
      pulses_reg <= 4'h0;
      sampled_reg <= 1'b0;
      recov_reg <= 1'b0;
      cmd_ready <= 1'b1;
      wr_data_taken <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
    end else begin
      wr_data_taken <= 1'b0;
      done <= 1'b0;
      if (tick) begin
        q_reg <= q_reg + 2'h1;
      end
      case (state_reg)
        HS_IDLE: begin
          scl_reg <= 1'b1;
          sda_oe_reg <= 1'b0;
          if (cmd_valid && cmd_ready && tick) begin
            cmd_ready <= 1'b0;
            nack <= 1'b0;
            recov_reg <= cmd_recover;
            pulses_reg <= 4'h0;
            q_reg <= 2'h0;
            state_reg <= cmd_recover ? HS_RECOV : HS_START;
          end
        end
        HS_RECOV: begin
          if (tick) begin
            case (q_reg)
              2'h0: sda_oe_reg <= 1'b0;
              2'h1: scl_reg <= 1'b1;
              2'h2: sampled_reg <= sda_s_reg;
              default: begin
                scl_reg <= 1'b0;
                pulses_reg <= pulses_reg + 4'h1;
                if (sampled_reg || pulses_reg == RECOVER_PULSES - 4'h1) begin
                  state_reg <= HS_START;
                end
              end
            endcase
          end
        end
        HS_START: begin
          if (tick) begin
            case (q_reg)
              2'h0: scl_reg <= 1'b1;
              2'h1: sda_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b1;
              default: begin
                scl_reg <= 1'b0;
                tx_reg <= cmd_ctrl;
                bitn_reg <= 3'h7;
                nbyte_reg <= 6'h00;
                state_reg <= recov_reg ? HS_STOP : HS_BIT;
              end
            endcase
          end
        end
        HS_BIT: begin
          if (tick) begin
            case (q_reg)
              2'h0: sda_oe_reg <= ~tx_reg[7];
              2'h1: scl_reg <= 1'b1;
              2'h2: scl_reg <= 1'b1;
              default: begin
                scl_reg <= 1'b0;
                tx_reg <= {tx_reg[6:0], 1'b0};
                bitn_reg <= bitn_reg - 3'h1;
                if (bitn_reg == 3'h0) begin
                  state_reg <= HS_ACK;
                end
              end
            endcase
          end
        end
        HS_ACK: begin
          if (tick) begin
            case (q_reg)
              2'h0: sda_oe_reg <= 1'b0;
              2'h1: scl_reg <= 1'b1;
              2'h2: sampled_reg <= sda_s_reg;
              default: begin
                scl_reg <= 1'b0;
                nbyte_reg <= nbyte_reg + 6'h01;
                bitn_reg <= 3'h7;
                if (sampled_reg || last_byte) begin
                  nack <= sampled_reg;
                  state_reg <= HS_STOP;
                end else if (nbyte_reg == 6'h00) begin
                  tx_reg <= cmd_word_addr;
                  state_reg <= HS_BIT;
                end else begin
                  tx_reg <= wr_data;
                  wr_data_taken <= 1'b1;
                  state_reg <= HS_BIT;
                end
              end
            endcase
          end
        end
        HS_STOP: begin
          if (tick) begin
            case (q_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_reg <= 1'b1;
              2'h2: sda_oe_reg <= 1'b0;
              default: begin
                done <= 1'b1;
                cmd_ready <= 1'b1;
                state_reg <= HS_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end

endmodule

// file: dv/tw_properties.sv
/*
  checker for the two-wire link and the memory write port.
  assumes it sits beside the link interface, every signal wired by name.
*/
`timescale 1ns/1ps
module tw_properties #(
  parameter int unsigned WR_CYCLES = tw_pkg::WR_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda,
  input wire logic write_busy,
  input wire logic mem_we,
  input wire tw_pkg::tw_byte_t mem_addr
);
  import tw_pkg::*;
  logic [31:0] busy_cnt;

  // length of the current write cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt <= '0;
    end else if (write_busy) begin
      busy_cnt <= busy_cnt + 1'b1;
    end else begin
      busy_cnt <= '0;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // acknowledge held one full link clock period
  sequence s_ack_hold;
    dev_sda_oe [*8] ##1 dev_sda_oe [*7] ##[1:3] !dev_sda_oe;
  endsequence
  property p_ack_hold;
    $rose(dev_sda_oe) |-> s_ack_hold;
  endproperty
  property p_ack_edge;
    $rose(dev_sda_oe) |-> !scl && $past(scl);
  endproperty
  property p_dev_low;
    dev_sda_oe |-> !dev_sda_o;
  endproperty
  property p_host_low;
    host_sda_oe |-> !host_sda_o;
  endproperty
  property p_stable_high;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  property p_stop_release;
    scl && $rose(sda) |-> !dev_sda_oe [*4];
  endproperty
  property p_busy_silent;
    write_busy |-> !$rose(dev_sda_oe);
  endproperty
  property p_we_busy;
    mem_we |-> write_busy;
  endproperty
  property p_page;
    mem_we && $past(mem_we) |-> mem_addr[7:4] == $past(mem_addr[7:4]) && mem_addr[3:0] > $past(mem_addr[3:0]);
  endproperty
  property p_busy_len;
    $fell(write_busy) |-> busy_cnt == WR_CYCLES;
  endproperty
  // a start pull-down is followed by the clock falling one quarter later
  property p_start_hold;
    scl && $rose(host_sda_oe) |-> scl [*4] ##1 !scl;
  endproperty

  a_ack_hold: assert property (p_ack_hold) else $error("ack not held one period");
  a_ack_edge: assert property (p_ack_edge) else $error("ack not at falling clock");
  a_dev_low: assert property (p_dev_low) else $error("device drives data high");
  a_host_low: assert property (p_host_low) else $error("master drives data high");
  a_stable_high: assert property (p_stable_high) else $error("device data moved with clock high");
  a_stop_release: assert property (p_stop_release) else $error("device drives after stop");
  a_busy_silent: assert property (p_busy_silent) else $error("ack during write cycle");
  a_we_busy: assert property (p_we_busy) else $error("array write outside write cycle");
  a_page: assert property (p_page) else $error("page or slot order broken");
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  a_start_hold: assert property (p_start_hold) else $error("start not followed by clock fall");
endmodule

// file: dv/tb_two_wire_eeprom_write_port.sv
/*
  bench: both ends of the two-wire write port joined by the link interface.
  assumes the package, interface and both design ends are compiled first.
*/
`timescale 1ns/1ps
module tb_two_wire_eeprom_write_port;
  import tw_pkg::*;
  localparam int WRC = 200;
  localparam logic [2:0] STRAP = 3'b101;
  localparam tw_byte_t CW = {CODE_MEM, STRAP, 1'b0};
  logic clk_sys, reset_n, cmd_valid, cmd_recover, write_protect, rev_lock;
  logic cmd_ready, wr_data_taken, done, nack, mem_we, write_busy, perm_lock, nk;
  tw_byte_t cmd_ctrl, cmd_word_addr, wr_data, mem_addr, mem_wdata;
  logic [4:0] cmd_len;
  tw_byte_t wbuf [32];
  tw_byte_t seen [256];
  tw_byte_t expd [256];
  int wr_idx, n_we, errors, n_tests, busy_run, busy_len;

  tw_if u_tw_if ();
  tw_master u_tw_master (.clk_sys(clk_sys), .reset_n(reset_n), .link(u_tw_if.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_recover(cmd_recover), .cmd_ctrl(cmd_ctrl), .cmd_word_addr(cmd_word_addr),
    .cmd_len(cmd_len), .wr_data(wr_data), .wr_data_taken(wr_data_taken), .done(done), .nack(nack));
  tw_eeprom_dev #(.WR_CYCLES(WRC)) u_tw_eeprom_dev (.clk_sys(clk_sys), .reset_n(reset_n),
    .link(u_tw_if.device), .chip_select_strap_2(STRAP[2]), .chip_select_strap_1(STRAP[1]),
    .chip_select_strap_0(STRAP[0]), .write_protect(write_protect), .reversible_half_lock_flag(rev_lock),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .write_busy(write_busy),
    .permanent_half_lock_flag(perm_lock));
  tw_properties #(.WR_CYCLES(WRC)) u_tw_properties (.clk_sys(clk_sys), .reset_n(reset_n), .scl(u_tw_if.scl),
    .host_sda_o(u_tw_if.host_sda_o), .host_sda_oe(u_tw_if.host_sda_oe), .dev_sda_o(u_tw_if.dev_sda_o),
    .dev_sda_oe(u_tw_if.dev_sda_oe), .sda(u_tw_if.sda), .write_busy(write_busy), .mem_we(mem_we),
    .mem_addr(mem_addr));

  // clock, data feed and array capture
  always #10 clk_sys = ~clk_sys;
  assign wr_data = wbuf[wr_idx[4:0]];
  always @(posedge clk_sys) if (wr_data_taken) wr_idx <= wr_idx + 1;
  always @(posedge clk_sys) if (mem_we) begin
    seen[mem_addr] <= mem_wdata;
    n_we <= n_we + 1;
  end

  // length of the last write cycle, counted on every clock it stands
  always @(posedge clk_sys) begin
    if (write_busy === 1'b1) begin
      busy_run <= busy_run + 1;
    end else if (busy_run != 0) begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
  end

  task automatic tally_and_finish();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // one command through the master, returns its acknowledge verdict
  task automatic xfer(input tw_byte_t ctrl, input tw_byte_t addr, input logic [4:0] len, input logic rec);
    @(posedge clk_sys);
    cmd_ctrl <= ctrl;
    cmd_word_addr <= addr;
    cmd_len <= len;
    cmd_recover <= rec;
    cmd_valid <= 1'b1;
    wr_idx <= 0;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_sys);
      if (cmd_ready === 1'b0) break;
    end
    check("ready_low", 0, cmd_ready);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 4000; i++) begin
      @(negedge clk_sys);
      if (done === 1'b1) break;
    end
    check("done", 1, done);
    check("ready_back", 1, cmd_ready);
    check("idle_wire", 2'b11, {u_tw_if.scl, u_tw_if.sda});
    nk = nack;
  endtask

  // busy may already stand when the frame's done pulse returns
  task automatic wait_write();
    for (int i = 0; i < 40 && write_busy !== 1'b1; i++) @(negedge clk_sys);
    check("busy_seen", 1, write_busy);
    for (int i = 0; i < 1000 && write_busy === 1'b1; i++) @(negedge clk_sys);
    check("busy_end", 0, write_busy);
    repeat (2) @(negedge clk_sys);
    check("busy_len", WRC, busy_len);
  endtask

  task automatic t_recover();
    xfer(8'h00, 8'h00, 5'h00, 1'b1);
    check("recover_nack", 0, nk);
  endtask

  task automatic fresh();
    for (int a = 0; a < 256; a++) begin
      seen[a] = 8'hEE;
      expd[a] = 8'hEE;
    end
    n_we = 0;
  endtask

  task automatic cmp_mem();
    for (int a = 0; a < 256; a++) check("mem_byte", expd[a], seen[a]);
  endtask

  task automatic t_byte_poll();
    fresh();
    wbuf[0] = 8'h5A;
    expd[8'h35] = 8'h5A;
    xfer(CW, 8'h35, 5'd1, 1'b0);
    check("ack_write", 0, nk);
    xfer(CW | 8'h01, 8'h00, 5'd0, 1'b0);
    check("poll_busy", 1, nk);
    for (int i = 0; i < 6 && nk !== 1'b0; i++) xfer(CW | 8'h01, 8'h00, 5'd0, 1'b0);
    check("poll_free", 0, nk);
    check("busy_at_ack", 0, write_busy);
    cmp_mem();
  endtask

  task automatic t_page_wrap();
    fresh();
    for (int n = 0; n < 18; n++) begin
      wbuf[n] = 8'h40 + 8'(n);
      expd[{4'h9, 4'hC + 4'(n)}] = wbuf[n];
    end
    xfer(CW, 8'h9C, 5'd18, 1'b0);
    check("ack_page", 0, nk);
    wait_write();
    check("we_count", 16, n_we);
    cmp_mem();
  endtask

  task automatic t_refuse();
    for (int k = 0; k < 2; k++) begin
      fresh();
      xfer(k == 0 ? {CODE_MEM, STRAP ^ 3'b001, 1'b0} : {4'h5, STRAP, 1'b0}, 8'h01, 5'd1, 1'b0);
      check("refused", 1, nk);
      repeat (30) @(negedge clk_sys);
      check("no_busy", 0, write_busy);
      check("no_write", 0, n_we);
    end
  endtask

  // lower half blocked, upper half written
  task automatic half_check();
    fresh();
    wbuf[0] = 8'hC3;
    expd[8'h80] = 8'hC3;
    xfer(CW, 8'h7F, 5'd1, 1'b0);
    wait_write();
    xfer(CW, 8'h80, 5'd1, 1'b0);
    wait_write();
    cmp_mem();
  endtask

  task automatic t_protect();
    fresh();
    @(posedge clk_sys);
    write_protect <= 1'b1;
    xfer(CW, 8'h90, 5'd1, 1'b0);
    check("ack_protected", 0, nk);
    wait_write();
    check("no_write", 0, n_we);
    @(posedge clk_sys);
    write_protect <= 1'b0;
    rev_lock <= 1'b1;
    half_check();
    @(posedge clk_sys);
    rev_lock <= 1'b0;
  endtask

  task automatic t_lock();
    xfer({CODE_LOCK, STRAP, 1'b0}, 8'h00, 5'd1, 1'b0);
    check("ack_lock", 0, nk);
    wait_write();
    check("lock_set", 1, perm_lock);
    xfer({CODE_LOCK, STRAP, 1'b0}, 8'h00, 5'd1, 1'b0);
    check("lock_refused", 1, nk);
    half_check();
  endtask

  initial begin
    clk_sys = 0;
    reset_n = 0;
    {cmd_valid, cmd_recover, write_protect, rev_lock} = '0;
    {cmd_ctrl, cmd_word_addr, cmd_len} = '0;
    {wr_idx, n_we, errors, n_tests, busy_run, busy_len} = '0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_recover();
    t_byte_poll();
    t_page_wrap();
    t_refuse();
    t_protect();
    t_lock();
    tally_and_finish();
  end

  // hang guard
  initial begin
    #(80000 * 20);
    errors++;
    tally_and_finish();
  end
endmodule
